// file: timer_channel_map.svh
// register map, field positions, reset values and prescaler taps of the timer channel
// Function
// - channel joins synchronous clearing only while its own sync bit holds 1
// - buffered register C or D never clears the counter through its clear source
// - buffered register produces no compare match and no input capture
// - pairing bit for B: 0 means B alone, 1 pairs B with D
// - buffered C or D ignores its pin mode and only buffers its partner
`ifndef TIMER_CHANNEL_MAP_SVH
`define TIMER_CHANNEL_MAP_SVH

// word indices on the bus; byte address is four times the index
`define TMR_CONTROL_IDX   16'hFE80
`define TMR_MODE_IDX      16'hFE81
`define TMR_SYNC_IDX      16'hFE82
`define TMR_IOSEL_IDX     16'hFE83
`define TMR_COUNTER_IDX   16'hFE84
`define TMR_GREG_A_IDX    16'hFE85
`define TMR_GREG_B_IDX    16'hFE86
`define TMR_GREG_C_IDX    16'hFE87
`define TMR_GREG_D_IDX    16'hFE88
`define TMR_STATUS_IDX    16'hFE89

// control register fields
`define CTRL_CLR_MSB      7
`define CTRL_CLR_LSB      5
`define CTRL_EDGE_MSB     4
`define CTRL_EDGE_LSB     3
`define CTRL_PSC_MSB      2
`define CTRL_PSC_LSB      0

// mode register fields
`define MODE_BFB_BIT      5
`define MODE_BFA_BIT      4
`define MODE_WR_MASK      8'h3F

// reset values
`define CTRL_RESET        8'h00
`define MODE_RESET        8'h00
`define SYNC_RESET        1'b0
`define IOSEL_RESET       4'h0
`define COUNTER_RESET     16'h0000
`define GREG_RESET        16'hFFFF

// prescaler taps: bit n of the free counter has a period of 2^(n+1) clocks
`define PSC_WIDTH         12
`define PSC_TAP_256       7
`define PSC_TAP_1024      9
`define PSC_TAP_4096      11

`endif

// file: timer_channel_pkg.sv
// types shared by the timer channel files
package timer_channel_pkg;

   typedef enum logic [2:0] {
      CLR_NONE   = 3'h0,
      CLR_BY_A   = 3'h1,
      CLR_BY_B   = 3'h2,
      CLR_SYNC   = 3'h3,
      CLR_NONE_H = 3'h4,
      CLR_BY_C   = 3'h5,
      CLR_BY_D   = 3'h6,
      CLR_SYNC_H = 3'h7
   } clear_src_e;

   typedef enum logic [2:0] {
      PSC_INT_0  = 3'h0,
      PSC_INT_1  = 3'h1,
      PSC_INT_2  = 3'h2,
      PSC_INT_3  = 3'h3,
      PSC_EXT_A  = 3'h4,
      PSC_1024   = 3'h5,
      PSC_256    = 3'h6,
      PSC_4096   = 3'h7
   } prescale_e;

   typedef enum logic [1:0] {
      EDGE_RISE  = 2'h0,
      EDGE_FALL  = 2'h1,
      EDGE_BOTH  = 2'h2,
      EDGE_BOTH2 = 2'h3
   } count_edge_e;

endpackage

// file: count_tick_gen.sv
// count clock selection and edge qualification for the channel counter
`timescale 1ns/1ps
`default_nettype none
`include "timer_channel_map.svh"

module count_tick_gen
   import timer_channel_pkg::*;
(
   // clock and reset
   input  wire logic       i_mclk,
   input  wire logic       i_reset_n,
   // selection
   input  wire logic [2:0] i_clock_prescale_sel,
   input  wire logic [1:0] i_count_edge_sel,
   input  wire logic       i_ext_clock_pin_a,
   // count event
   output logic            o_tick
);

   logic [`PSC_WIDTH-1:0] psc_q;
   logic [`PSC_WIDTH-1:0] psc_d;
   logic                  src_q;
   logic                  src_d;
   logic                  tick_q;
   logic                  tick_d;
   logic                  src_now;

   always_comb begin
      psc_d   = psc_q + `PSC_WIDTH'(1);
      src_now = 1'b0;
      case (prescale_e'(i_clock_prescale_sel))
         PSC_EXT_A: src_now = i_ext_clock_pin_a;
         PSC_1024:  src_now = psc_q[`PSC_TAP_1024];
         PSC_256:   src_now = psc_q[`PSC_TAP_256];
         PSC_4096:  src_now = psc_q[`PSC_TAP_4096];
         default:   src_now = 1'b0;
      endcase
      src_d = src_now;
      if (!i_clock_prescale_sel[2]) begin
         // low codes count on every clock, no edge to qualify
         tick_d = 1'b1;
      end else begin
         case (count_edge_e'(i_count_edge_sel))
            EDGE_RISE: tick_d = src_now & ~src_q;
            EDGE_FALL: tick_d = ~src_now & src_q;
            default:   tick_d = src_now ^ src_q;
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         psc_q  <= '0;
         src_q  <= 1'b0;
         tick_q <= 1'b0;
      end else begin
         psc_q  <= psc_d;
         src_q  <= src_d;
         tick_q <= tick_d;
      end
   end

   assign o_tick = tick_q;

endmodule // count_tick_gen
`default_nettype wire

// file: timer_channel_ctrl.sv
// one timer channel: counter, general registers, clear and buffer control, wishbone slave
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "timer_channel_map.svh"

module timer_channel_ctrl
   import timer_channel_pkg::*;
#(
   parameter int CNT_W = 16
)(
   // clock and reset
   input  wire logic             i_mclk,
   input  wire logic             i_reset_n,
   // wishbone slave
   input  wire logic             i_wb_cyc,
   input  wire logic             i_wb_stb,
   input  wire logic             i_wb_we,
   input  wire logic [17:2]      i_wb_adr,
   input  wire logic [31:0]      i_wb_dat,
   input  wire logic [3:0]       i_wb_sel,
   output logic      [31:0]      o_wb_dat,
   output logic                  o_wb_ack,
   // timer pins
   input  wire logic             i_ext_clock_pin_a,
   input  wire logic [3:0]       i_capture_pin,
   // synchronous clearing with other channels
   input  wire logic             i_sync_clear,
   output logic                  o_sync_clear,
   // channel state
   output logic      [CNT_W-1:0] o_channel_counter,
   output logic      [3:0]       o_match,
   output logic      [3:0]       o_capture
);

   // register state
   logic [7:0]       ctrl_q;
   logic [7:0]       ctrl_d;
   logic [7:0]       mode_q;
   logic [7:0]       mode_d;
   logic             sync_en_q;
   logic             sync_en_d;
   logic [3:0]       iosel_q;
   logic [3:0]       iosel_d;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic [CNT_W-1:0] greg_q [4];
   logic [CNT_W-1:0] greg_d [4];
   logic [7:0]       status_q;
   logic [7:0]       status_d;
   logic [3:0]       pin_q;
   logic [3:0]       match_q;
   logic [3:0]       match_d;
   logic [3:0]       cap_q;
   logic [3:0]       cap_d;
   logic             sync_out_q;
   logic             sync_out_d;
   logic             ack_q;
   logic             ack_d;
   logic [31:0]      rdat_q;
   logic [31:0]      rdat_d;

   // decoded controls and per-register events
   logic             tick;
   logic             pair_a_buffer_sel;
   logic             pair_b_buffer_sel;
   logic [3:0]       buffered;
   logic [3:0]       match_w;
   logic [3:0]       cap_w;
   logic [3:0]       hit_w;
   logic             own_clear;
   logic             ext_clear;
   logic             wr_stb;
   logic             rd_stb;
   clear_src_e       clear_source_sel;

   count_tick_gen u_tick (
      .i_mclk               (i_mclk),
      .i_reset_n            (i_reset_n),
      .i_clock_prescale_sel (ctrl_q[`CTRL_PSC_MSB:`CTRL_PSC_LSB]),
      .i_count_edge_sel     (ctrl_q[`CTRL_EDGE_MSB:`CTRL_EDGE_LSB]),
      .i_ext_clock_pin_a    (i_ext_clock_pin_a),
      .o_tick               (tick)
   );

   assign pair_a_buffer_sel = mode_q[`MODE_BFA_BIT];
   assign pair_b_buffer_sel = mode_q[`MODE_BFB_BIT];
   assign clear_source_sel  = clear_src_e'(ctrl_q[`CTRL_CLR_MSB:`CTRL_CLR_LSB]);

   // only C and D can act as buffers; A and B always keep their own duty
   assign buffered = {pair_b_buffer_sel, pair_a_buffer_sel, 2'b00};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_event
         // a buffer register neither compares nor captures; its pin mode is ignored
         assign match_w[gi] = tick & ~iosel_q[gi] & (cnt_q == greg_q[gi])
                              & ~buffered[gi];
         assign cap_w[gi]   = iosel_q[gi] & i_capture_pin[gi] & ~pin_q[gi]
                              & ~buffered[gi];
         assign hit_w[gi]   = match_w[gi] | cap_w[gi];
      end
   endgenerate

   // clear source decode
   always_comb begin
      own_clear = 1'b0;
      ext_clear = 1'b0;
      case (clear_source_sel)
         CLR_BY_A:   own_clear = hit_w[0];
         CLR_BY_B:   own_clear = hit_w[1];
         CLR_BY_C:   own_clear = hit_w[2] & ~pair_a_buffer_sel;
         CLR_BY_D:   own_clear = hit_w[3] & ~pair_b_buffer_sel;
         CLR_SYNC,
         CLR_SYNC_H: ext_clear = sync_en_q & i_sync_clear;
         default:    own_clear = 1'b0;
      endcase
   end

   assign wr_stb = i_wb_cyc & i_wb_stb & i_wb_we & ack_q;
   assign rd_stb = i_wb_cyc & i_wb_stb & ~ack_q;

   function automatic logic [CNT_W-1:0] merge16(input logic [CNT_W-1:0] old_v,
                                                 input logic [31:0]      new_v,
                                                 input logic [3:0]       sel);
      logic [CNT_W-1:0] r;
      r = old_v;
      if (sel[0]) begin
         r[7:0] = new_v[7:0];
      end
      if (sel[1]) begin
         r[CNT_W-1:8] = new_v[CNT_W-1:8];
      end
      return r;
   endfunction

   // next state of the channel
   always_comb begin
      ctrl_d     = ctrl_q;
      mode_d     = mode_q;
      sync_en_d  = sync_en_q;
      iosel_d    = iosel_q;
      greg_d     = greg_q;
      match_d    = match_w;
      cap_d      = cap_w;
      sync_out_d = sync_en_q & own_clear;
      cnt_d      = tick ? cnt_q + CNT_W'(1) : cnt_q;
      if (own_clear | ext_clear) begin
         cnt_d = '0;
      end
      // input capture latches the current count
      for (int i = 0; i < 4; i++) begin
         if (cap_w[i]) begin
            greg_d[i] = cnt_q;
         end
      end
      // buffered pairs: compare reloads from the buffer, capture pushes old value into it
      if (pair_a_buffer_sel) begin
         if (match_w[0]) begin
            greg_d[0] = greg_q[2];
         end
         if (cap_w[0]) begin
            greg_d[2] = greg_q[0];
         end
      end
      if (pair_b_buffer_sel) begin
         if (match_w[1]) begin
            greg_d[1] = greg_q[3];
         end
         if (cap_w[1]) begin
            greg_d[3] = greg_q[1];
         end
      end
      // sticky flags: low nibble match, high nibble capture; set wins over clear
      status_d = status_q;
      if (wr_stb && i_wb_sel[0] && i_wb_adr == `TMR_STATUS_IDX) begin
         status_d = status_q & ~i_wb_dat[7:0];
      end
      status_d = status_d | {cap_w, match_w};
      // software writes
      if (wr_stb) begin
         case (i_wb_adr)
            `TMR_CONTROL_IDX: begin
               if (i_wb_sel[0]) begin
                  ctrl_d = i_wb_dat[7:0];
               end
            end
            `TMR_MODE_IDX: begin
               if (i_wb_sel[0]) begin
                  mode_d = i_wb_dat[7:0] & `MODE_WR_MASK;
               end
            end
            `TMR_SYNC_IDX: begin
               if (i_wb_sel[0]) begin
                  sync_en_d = i_wb_dat[0];
               end
            end
            `TMR_IOSEL_IDX: begin
               if (i_wb_sel[0]) begin
                  iosel_d = i_wb_dat[3:0];
               end
            end
            `TMR_COUNTER_IDX: cnt_d = merge16(cnt_q, i_wb_dat, i_wb_sel);
            `TMR_GREG_A_IDX:  greg_d[0] = merge16(greg_q[0], i_wb_dat, i_wb_sel);
            `TMR_GREG_B_IDX:  greg_d[1] = merge16(greg_q[1], i_wb_dat, i_wb_sel);
            `TMR_GREG_C_IDX:  greg_d[2] = merge16(greg_q[2], i_wb_dat, i_wb_sel);
            `TMR_GREG_D_IDX:  greg_d[3] = merge16(greg_q[3], i_wb_dat, i_wb_sel);
            default: ;
         endcase
      end
   end

   // bus answer: one wait cycle, unmapped reads return zero
   always_comb begin
      ack_d  = i_wb_cyc & i_wb_stb & ~ack_q;
      rdat_d = rdat_q;
      if (rd_stb) begin
         rdat_d = 32'h0000_0000;
         case (i_wb_adr)
            `TMR_CONTROL_IDX: rdat_d[7:0]       = ctrl_q;
            `TMR_MODE_IDX:    rdat_d[7:0]       = mode_q;
            `TMR_SYNC_IDX:    rdat_d[0]         = sync_en_q;
            `TMR_IOSEL_IDX:   rdat_d[3:0]       = iosel_q;
            `TMR_COUNTER_IDX: rdat_d[CNT_W-1:0] = cnt_q;
            `TMR_GREG_A_IDX:  rdat_d[CNT_W-1:0] = greg_q[0];
            `TMR_GREG_B_IDX:  rdat_d[CNT_W-1:0] = greg_q[1];
            `TMR_GREG_C_IDX:  rdat_d[CNT_W-1:0] = greg_q[2];
            `TMR_GREG_D_IDX:  rdat_d[CNT_W-1:0] = greg_q[3];
            `TMR_STATUS_IDX:  rdat_d[7:0]       = status_q;
            default:          rdat_d            = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ctrl_q     <= `CTRL_RESET;
         mode_q     <= `MODE_RESET;
         sync_en_q  <= `SYNC_RESET;
         iosel_q    <= `IOSEL_RESET;
         cnt_q      <= `COUNTER_RESET;
         for (int i = 0; i < 4; i++) begin
            greg_q[i] <= `GREG_RESET;
         end
         status_q   <= 8'h00;
         pin_q      <= 4'h0;
         match_q    <= 4'h0;
         cap_q      <= 4'h0;
         sync_out_q <= 1'b0;
         ack_q      <= 1'b0;
         rdat_q     <= 32'h0000_0000;
      end else begin
         ctrl_q     <= ctrl_d;
         mode_q     <= mode_d;
         sync_en_q  <= sync_en_d;
         iosel_q    <= iosel_d;
         cnt_q      <= cnt_d;
         greg_q     <= greg_d;
         status_q   <= status_d;
         pin_q      <= i_capture_pin;
         match_q    <= match_d;
         cap_q      <= cap_d;
         sync_out_q <= sync_out_d;
         ack_q      <= ack_d;
         rdat_q     <= rdat_d;
      end
   end

   assign o_wb_ack          = ack_q;
   assign o_wb_dat          = rdat_q;
   assign o_sync_clear      = sync_out_q;
   assign o_channel_counter = cnt_q;
   assign o_match           = match_q;
   assign o_capture         = cap_q;

endmodule // timer_channel_ctrl
`default_nettype wire

// file: timer_channel_ctrl_chk.sv
// assertion checker for the timer channel, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module timer_channel_ctrl_chk #(
   parameter int CNT_W = 16
)(
   // clock, reset and bus
   input wire logic             i_mclk,
   input wire logic             i_reset_n,
   input wire logic             i_wb_cyc,
   input wire logic             i_wb_stb,
   input wire logic             i_wb_we,
   input wire logic [17:2]      i_wb_adr,
   input wire logic [31:0]      i_wb_dat,
   input wire logic [3:0]       i_wb_sel,
   input wire logic             o_wb_ack,
   // channel
   input wire logic             i_sync_clear,
   input wire logic             o_sync_clear,
   input wire logic [CNT_W-1:0] o_channel_counter,
   input wire logic [3:0]       o_match,
   input wire logic [3:0]       o_capture
);
   logic [7:0] ctl_q, ctl_d;
   logic [1:0] buf_q, buf_d;
   logic       sync_q, sync_d;
   logic       wr;
   assign wr = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack;
   // shadow of the control, pairing and sync bits as software writes them
   always_comb begin
      ctl_d  = ctl_q;
      buf_d  = buf_q;
      sync_d = sync_q;
      if (wr && i_wb_sel[0]) begin
         case (i_wb_adr)
            16'hFE80: ctl_d = i_wb_dat[7:0];
            16'hFE81: buf_d = i_wb_dat[5:4];
            16'hFE82: sync_d = i_wb_dat[0];
            default: ;
         endcase
      end
   end
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ctl_q  <= 8'h00;
         buf_q  <= 2'h0;
         sync_q <= 1'b0;
      end else begin
         ctl_q  <= ctl_d;
         buf_q  <= buf_d;
         sync_q <= sync_d;
      end
   end
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_reset_n);
   a_ack_one_pulse: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
      else $error("bus ack is not a single pulse");
   a_sync_out_bit: assert property (o_sync_clear |-> $past(sync_q))
      else $error("sync clear out while sync bit is 0");
   a_sync_in_zero: assert property (i_sync_clear && sync_q && ctl_q[6:5] == 2'h3 && !wr
      |=> o_channel_counter == '0)
      else $error("sync clear in did not zero the counter");
   a_buf_c_quiet: assert property (buf_q[0] |=> !o_match[2] && !o_capture[2])
      else $error("buffered register c produced an event");
   a_buf_d_quiet: assert property (buf_q[1] |=> !o_match[3] && !o_capture[3])
      else $error("buffered register d produced an event");
   a_buf_no_clear: assert property (buf_q[1] && ctl_q[7:5] == 3'h6 && !wr
      && o_channel_counter != '0 && !(&o_channel_counter) |=> o_channel_counter != '0)
      else $error("buffered register d cleared the counter");
   a_fast_count: assert property (ctl_q[2:0] < 3'h4 && $past(ctl_q[2:0]) < 3'h4
      && $past(ctl_q[2:0], 2) < 3'h4 && $past(i_reset_n, 2) && ctl_q[7:5] == 3'h0 && !wr
      |=> o_channel_counter == CNT_W'($past(o_channel_counter) + 1'b1))
      else $error("counter did not count every clock");
   c_sync_out: cover property (o_sync_clear);
   c_sync_in: cover property (i_sync_clear && sync_q);
   c_pair_b: cover property (buf_q[1] && o_match[1]);
endmodule // timer_channel_ctrl_chk

bind timer_channel_ctrl timer_channel_ctrl_chk #(.CNT_W(CNT_W)) u_chk (.*);
`default_nettype wire

// file: tb_timer_channel_ctrl.sv
// self-checking testbench for the timer channel control block
`timescale 1ns/1ps
`default_nettype none
module tb_timer_channel_ctrl import timer_channel_pkg::*;;
   logic        i_mclk    = 1'b0;
   logic        i_reset_n = 1'b0;
   logic        wb_cyc    = 1'b0;
   logic        wb_stb    = 1'b0;
   logic        wb_we     = 1'b0;
   logic [15:0] wb_adr    = 16'h0000;
   logic [31:0] wb_dat    = 32'h0;
   logic [3:0]  wb_sel    = 4'h0;
   logic [31:0] rd_dat;
   logic        wb_ack;
   logic        ext_pin   = 1'b0;
   logic        sync_in   = 1'b0;
   logic [3:0]  cap_pin   = 4'h0;
   logic        sync_out;
   logic [15:0] cnt_out;
   logic [3:0]  match_out;
   logic [3:0]  cap_out;
   logic [31:0] exp_q[$];
   // event note: sync out, match, capture, counter during the pulse
   logic [24:0] ev_q[$];
   int          fail_count = 0;
   int          num_checks = 0;

   always #2.5 i_mclk = ~i_mclk;

   timer_channel_ctrl #(.CNT_W(16)) dut (
      .i_mclk            (i_mclk),
      .i_reset_n         (i_reset_n),
      .i_wb_cyc          (wb_cyc),
      .i_wb_stb          (wb_stb),
      .i_wb_we           (wb_we),
      .i_wb_adr          (wb_adr),
      .i_wb_dat          (wb_dat),
      .i_wb_sel          (wb_sel),
      .o_wb_dat          (rd_dat),
      .o_wb_ack          (wb_ack),
      .i_ext_clock_pin_a (ext_pin),
      .i_capture_pin     (cap_pin),
      .i_sync_clear      (sync_in),
      .o_sync_clear      (sync_out),
      .o_channel_counter (cnt_out),
      .o_match           (match_out),
      .o_capture         (cap_out)
   );

   task automatic wb(input logic we, input logic [15:0] a, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge i_mclk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we  <= we;
      wb_adr <= a;
      wb_dat <= d;
      wb_sel <= 4'h3;
      while (wb_ack !== 1'b1 && t < 20) begin
         @(posedge i_mclk);
         t++;
      end
      if (t == 20) begin
         fail_count++;
         $display("[ERR] bus ack expected 1 seen 0");
      end
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      wb(1'b0, a, 32'h0);
   endtask

   // external pin pulses, each level held long enough to be seen
   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge i_mclk);
         ext_pin <= 1'b1;
         repeat (4) @(posedge i_mclk);
         ext_pin <= 1'b0;
         repeat (3) @(posedge i_mclk);
      end
   endtask

   always @(posedge i_mclk) begin
      if (wb_ack === 1'b1 && wb_cyc && !wb_we && exp_q.size() > 0) begin
         num_checks++;
         if (rd_dat !== exp_q[0]) begin
            fail_count++;
            $display("[ERR] reg %h expected %h seen %h", wb_adr, exp_q[0], rd_dat);
         end
         void'(exp_q.pop_front());
      end
   end

   // event outputs: each pulse is held against the oldest note
   always @(posedge i_mclk) begin
      if (i_reset_n && {sync_out, match_out, cap_out} !== 9'h000) begin
         num_checks++;
         if (ev_q.size() == 0) begin
            fail_count++;
            $display("[ERR] event expected none seen %h", {sync_out, match_out, cap_out});
         end else begin
            if ({sync_out, match_out, cap_out, cnt_out} !== ev_q[0]) begin
               fail_count++;
               $display("[ERR] event expected %h seen %h", ev_q[0],
                        {sync_out, match_out, cap_out, cnt_out});
            end
            void'(ev_q.pop_front());
         end
      end
   end

   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      repeat (40000) @(posedge i_mclk);
      fail_count++;
      $display("[ERR] watchdog expected finish seen timeout");
      final_report();
   end

   initial begin
      int n;
      void'($urandom(32'h4842));
      repeat (8) @(posedge i_mclk);
      i_reset_n <= 1'b1;
      rd(16'hFE80, 32'h0);
      rd(16'hFE86, 32'hFFFF);
      rd(16'hFE90, 32'h0);
      wb(1'b1, 16'hFE81, 32'hFF);
      rd(16'hFE81, 32'h3F);
      wb(1'b1, 16'hFE81, 32'h0);
      $display("test registers done");
      for (int e = 0; e < 3; e++) begin
         n = $urandom_range(4, 1);
         wb(1'b1, 16'hFE80, {27'h0, e[1:0], 3'h4});
         wb(1'b1, 16'hFE84, 32'h0);
         pulse(n);
         rd(16'hFE84, (e == 2) ? 2 * n : n);
      end
      $display("test count edges done");
      for (int b = 0; b < 2; b++) begin
         wb(1'b1, 16'hFE81, b ? 32'h0 : 32'h20);
         wb(1'b1, 16'hFE89, 32'hFF);
         wb(1'b1, 16'hFE80, 32'hC4);
         wb(1'b1, 16'hFE88, 32'h2);
         wb(1'b1, 16'hFE84, 32'h0);
         if (b) ev_q.push_back({1'b0, 4'h8, 4'h0, 16'h0000});
         pulse(5);
         rd(16'hFE84, b ? 32'h2 : 32'h5);
         rd(16'hFE89, b ? 32'h8 : 32'h0);
      end
      $display("test buffered clear done");
      wb(1'b1, 16'hFE80, 32'h64);
      for (int s = 0; s < 2; s++) begin
         wb(1'b1, 16'hFE82, s);
         wb(1'b1, 16'hFE84, 32'h5);
         @(posedge i_mclk);
         sync_in <= 1'b1;
         @(posedge i_mclk);
         sync_in <= 1'b0;
         rd(16'hFE84, s ? 32'h0 : 32'h5);
      end
      $display("test sync clear done");
      wb(1'b1, 16'hFE80, 32'h44);
      for (int b = 0; b < 2; b++) begin
         wb(1'b1, 16'hFE81, b ? 32'h0 : 32'h20);
         wb(1'b1, 16'hFE86, 32'h3);
         wb(1'b1, 16'hFE88, 32'h7);
         wb(1'b1, 16'hFE84, 32'h0);
         ev_q.push_back({1'b1, 4'h2, 4'h0, 16'h0000});
         pulse(4);
         rd(16'hFE86, b ? 32'h3 : 32'h7);
         rd(16'hFE84, 32'h0);
      end
      $display("test pairing done");
      // 8192 clocks between counter write and read: whole periods of each divider
      for (int c = 5; c < 8; c++) begin
         wb(1'b1, 16'hFE80, c);
         wb(1'b1, 16'hFE84, 32'h0);
         if (c != 7) begin
            ev_q.push_back({1'b0, 4'h2, 4'h0, 16'h0004});
            ev_q.push_back({1'b0, 4'h8, 4'h0, 16'h0008});
         end
         repeat (8191) @(posedge i_mclk);
         rd(16'hFE84, (c == 5) ? 32'd8 : (c == 6) ? 32'd32 : 32'd2);
      end
      $display("test prescaler done");
      wb(1'b1, 16'hFE80, 32'h04);
      wb(1'b1, 16'hFE83, 32'hF);
      for (int b = 0; b < 2; b++) begin
         wb(1'b1, 16'hFE81, b ? 32'h0 : 32'h30);
         wb(1'b1, 16'hFE85, 32'hA);
         wb(1'b1, 16'hFE86, 32'hB);
         wb(1'b1, 16'hFE87, 32'hC);
         wb(1'b1, 16'hFE89, 32'hFF);
         wb(1'b1, 16'hFE84, 32'h11);
         ev_q.push_back({1'b0, 4'h0, b ? 4'hF : 4'h3, 16'h0011});
         cap_pin <= 4'hF;
         @(posedge i_mclk);
         cap_pin <= 4'h0;
         rd(16'hFE87, b ? 32'h11 : 32'hA);
         rd(16'hFE89, b ? 32'hF0 : 32'h30);
      end
      $display("test capture done");
      repeat (4) @(posedge i_mclk);
      if (ev_q.size() != 0) begin
         fail_count++;
         $display("[ERR] events expected 0 left seen %0d", ev_q.size());
      end
      final_report();
   end
endmodule // tb_timer_channel_ctrl
`default_nettype wire
